// >>> pkg/cdf_pkg.sv
// constants, register map and types for the caption data capture fifo
package cdf_pkg;
	// register offsets on the plain register port
	localparam logic [7:0] GEN_STATUS_ADDR = 8'h00;
	localparam logic [7:0] CAP_STATUS_ADDR = 8'h1C;
	localparam logic [7:0] CAP_DATA_ADDR   = 8'h1D;
	localparam logic [7:0] RESET_BYTE      = 8'h00;

	// caption_status bit positions
	localparam int ST_CAP_EN  = 0;
	localparam int ST_EDS_EN  = 1;
	localparam int ST_INT_EN  = 2;
	localparam int ST_AVAIL   = 3;
	localparam int ST_OVF     = 4;
	localparam int ST_PERR    = 5;
	localparam int ST_POS     = 6;
	localparam int ST_SRC     = 7;
	// general status bit that mirrors the caption interrupt
	localparam int GEN_INT_BIT = 0;

	// fifo geometry and entry layout {source, position, parity, char}
	localparam int         ENTRY_W    = 10;
	localparam int         PTR_W      = 4;
	localparam int         CNT_W      = 5;
	localparam int         E_SRC      = 9;
	localparam int         E_POS      = 8;
	localparam logic [4:0] FULL_LEVEL = 5'h10;
	localparam logic [4:0] HALF_LEVEL = 5'h08;
	localparam logic [3:0] PTR_STEP   = 4'h1;
	localparam logic [4:0] CNT_STEP   = 5'h01;

	// target lines
	localparam logic [8:0] CAP_LINE = 9'h015;
	localparam logic [8:0] EDS_LINE = 9'h11C;

	// slicing and bit timing
	localparam logic [7:0] SLICE_LEVEL = 8'h50;
	localparam logic [2:0] RUNIN_LAST  = 3'h5;
	localparam logic [2:0] START_CODE  = 3'h1;
	localparam logic [3:0] START_LAST  = 4'h2;
	localparam logic [3:0] DATA_LAST   = 4'hF;
	localparam logic [2:0] BYTE_LAST   = 3'h7;
	localparam int CLK_MHZ     = 100;
	localparam int BIT_NS      = 1987;
	localparam int BIT_CYC     = (BIT_NS * CLK_MHZ) / 1000;
	localparam logic [7:0] BIT_RELOAD = 8'(BIT_CYC - 1);
	localparam logic [7:0] LEAD_LOAD  = 8'(BIT_CYC + BIT_CYC / 4 - 1);

	typedef enum logic [3:0] {
		CDF_IDLE  = 4'b0001,
		CDF_RUNIN = 4'b0010,
		CDF_START = 4'b0100,
		CDF_DATA  = 4'b1000
	} cdf_slice_st_t;
endpackage

// >>> rtl/cdf_entry_mem.sv
// 16 x 10 entry store with registered read and write-through bypass
`timescale 1ns/1ps
module cdf_entry_mem
	import cdf_pkg::*;
(
	input  wire logic               mclk_i,  // system clock
	input  wire logic               nrst_i,  // sync reset, active low
	input  wire logic               we_i,    // write enable
	input  wire logic [PTR_W-1:0]   waddr_i, // write address
	input  wire logic [ENTRY_W-1:0] wdata_i, // write data
	input  wire logic [PTR_W-1:0]   raddr_i, // read address
	output logic      [ENTRY_W-1:0] rdata_o  // registered read data
);
	logic [ENTRY_W-1:0] mem_ff [16];

	always_ff @(posedge mclk_i)
	begin
		if (we_i)
			mem_ff[waddr_i] <= wdata_i;
	end

	// bypass so a byte written into an empty fifo shows at once
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			rdata_o <= '0;
		else if (we_i && (waddr_i == raddr_i))
			rdata_o <= wdata_i;
		else
			rdata_o <= mem_ff[raddr_i];
	end
endmodule // cdf_entry_mem

// >>> rtl/cdf_line_slicer.sv
// slices the luma of one target line into start code and two data bytes
`timescale 1ns/1ps
module cdf_line_slicer
	import cdf_pkg::*;
(
	input  wire logic       mclk_i,       // system clock
	input  wire logic       nrst_i,       // sync reset, active low
	input  wire logic [7:0] luma_i,       // separated luma samples
	input  wire logic       line_start_i, // pulse at each line start
	input  wire logic       arm_i,        // pulse: this line is a target
	output logic      [7:0] byte_o,       // captured byte, lsb first on air
	output logic            byte_vld_o,   // one-cycle pulse per byte
	output logic            byte_high_o   // byte is the second of the line
);
	cdf_slice_st_t st_ff;
	logic       slice_ff;
	logic       prev_ff;
	logic [2:0] edge_cnt_ff;
	logic [7:0] timer_ff;
	logic [3:0] bit_idx_ff;
	logic [2:0] start_sr_ff;
	logic [7:0] data_sr_ff;
	logic       rise;
	logic       tick;

	assign rise = slice_ff && !prev_ff;
	assign tick = (timer_ff == 8'h00);

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			slice_ff <= 1'b0;
			prev_ff  <= 1'b0;
		end
		else
		begin
			slice_ff <= (luma_i >= SLICE_LEVEL);
			prev_ff  <= slice_ff;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			st_ff       <= CDF_IDLE;
			edge_cnt_ff <= 3'h0;
			timer_ff    <= 8'h00;
			bit_idx_ff  <= 4'h0;
			start_sr_ff <= 3'h0;
			data_sr_ff  <= 8'h00;
		end
		else if (arm_i)
		begin
			st_ff       <= CDF_RUNIN;
			edge_cnt_ff <= 3'h0;
		end
		else if (line_start_i)
			st_ff <= CDF_IDLE;
		else
		begin
			case (st_ff)
				CDF_IDLE: ;
				CDF_RUNIN:
					// each run-in edge re-aligns the bit clock
					if (rise)
					begin
						timer_ff    <= LEAD_LOAD;
						edge_cnt_ff <= edge_cnt_ff + 3'h1;
						if (edge_cnt_ff == RUNIN_LAST)
						begin
							st_ff       <= CDF_START;
							bit_idx_ff  <= 4'h0;
							start_sr_ff <= 3'h0;
						end
					end
				CDF_START:
					if (tick)
					begin
						timer_ff    <= BIT_RELOAD;
						start_sr_ff <= {start_sr_ff[1:0], slice_ff};
						bit_idx_ff  <= bit_idx_ff + 4'h1;
						if (bit_idx_ff == START_LAST)
						begin
							bit_idx_ff <= 4'h0;
							if ({start_sr_ff[1:0], slice_ff} == START_CODE) // R3
								st_ff <= CDF_DATA;
							else
								st_ff <= CDF_IDLE;
						end
					end
					else
						timer_ff <= timer_ff - 8'h01;
				CDF_DATA:
					if (tick)
					begin
						timer_ff   <= BIT_RELOAD;
						data_sr_ff <= {slice_ff, data_sr_ff[7:1]};
						bit_idx_ff <= bit_idx_ff + 4'h1;
						if (bit_idx_ff == DATA_LAST)
							st_ff <= CDF_IDLE;
					end
					else
						timer_ff <= timer_ff - 8'h01;
				default:
					st_ff <= CDF_IDLE;
			endcase
		end
	end

	// low byte first, then high byte
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			byte_o      <= 8'h00;
			byte_vld_o  <= 1'b0;
			byte_high_o <= 1'b0;
		end
		else
		begin
			byte_vld_o <= 1'b0;
			if ((st_ff == CDF_DATA) && tick && (bit_idx_ff[2:0] == BYTE_LAST)
				&& !arm_i && !line_start_i)
			begin
				byte_o      <= {slice_ff, data_sr_ff[7:1]}; // R7
				byte_vld_o  <= 1'b1;
				byte_high_o <= bit_idx_ff[3];
			end
		end
	end

	AST_BYTE_FROM_DATA: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R3
		byte_vld_o |-> $past(st_ff) == CDF_DATA)
		else $error("byte emitted outside data phase");
endmodule // cdf_line_slicer

// >>> rtl/cdf_capture_top.sv
// caption and extended data capture: line select, fifo, status registers
//
// Summary of operation
// (R1) capture line 21 odd, 284 even
// (R2) separate caption and extended data enables
// (R3) capture only after run-in and 001
// (R4) byte is seven-bit code plus parity
// (R5) keep parity bit, flag parity errors
// (R6) sixteen entry ten-bit fifo
// (R7) low byte first, then high byte
// (R8) entries tagged with source and position
// (R9) data available high when not empty
// (R10) interrupt pin at half full when enabled
// (R11) interrupt mirrored in general status flag
// (R12) head entry visible; data read advances
// (R13) write into full fifo sets overflow
// (R14) data read without write clears overflow
// (R15) coinciding read and write: read wins
// (R16) coinciding write keeps overflow; writes dropped
// (R17) both enables cleared flushes the fifo
// (R18) host drains fifo soon after interrupt
// (R19) decode from separated luma only
// (R20) interrupt drops below half or disabled
// (R21) pointers and fill flags stay consistent
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module cdf_capture_top
	import cdf_pkg::*;
(
	input  wire logic       mclk_i,              // system clock, 100 MHz
	input  wire logic       nrst_i,              // sync reset, active low
	input  wire logic [7:0] luma_i,              // luma after y/c separation
	input  wire logic       line_start_i,        // pulse at start of a line
	input  wire logic [8:0] line_num_i,          // frame line number
	input  wire logic       field_odd_i,         // high in the odd field
	input  wire logic [7:0] reg_addr_i,          // register address
	input  wire logic [7:0] reg_wdata_i,         // register write data
	input  wire logic       reg_wr_i,            // write strobe
	input  wire logic       reg_rd_i,            // read strobe
	output logic      [7:0] reg_rdata_o,         // read data, cycle after strobe
	output logic            caption_interrupt_o  // half-full interrupt pin
);
	import cdf_pkg::*;

	logic               caption_enable_ff;
	logic               extended_data_enable_ff;
	logic               int_enable_ff;
	logic               src_ff;
	logic               ovf_ff;
	logic               int_ff;
	logic [PTR_W-1:0]   wr_ptr_ff;
	logic [PTR_W-1:0]   rd_ptr_ff;
	logic [CNT_W-1:0]   count_ff;
	logic [PTR_W-1:0]   nxt_rd_ptr;
	logic [CNT_W-1:0]   nxt_count;
	logic [ENTRY_W-1:0] head;
	logic [ENTRY_W-1:0] entry;
	logic [7:0]         slice_byte;
	logic               slice_vld;
	logic               slice_high;
	logic               arm;
	logic               flush;
	logic               full;
	logic               avail;
	logic               push_req;
	logic               push;
	logic               pop;
	logic               drop;
	logic [7:0]         status_byte;

	// odd parity holds when the xor of all eight bits is one
	function automatic logic odd_ok(input logic [7:0] b);
		odd_ok = ^b;
	endfunction

	// control bits written by software
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			caption_enable_ff       <= 1'b0;
			extended_data_enable_ff <= 1'b0;
			int_enable_ff           <= 1'b0;
		end
		else if (reg_wr_i && (reg_addr_i == CAP_STATUS_ADDR))
		begin
			caption_enable_ff       <= reg_wdata_i[ST_CAP_EN]; // R2
			extended_data_enable_ff <= reg_wdata_i[ST_EDS_EN]; // R2
			int_enable_ff           <= reg_wdata_i[ST_INT_EN];
		end
	end

	assign flush = !caption_enable_ff && !extended_data_enable_ff; // R17

	// arm the slicer only on an enabled target line of the right field
	assign arm = line_start_i && (
		(caption_enable_ff && field_odd_i && (line_num_i == CAP_LINE)) || // R1
		(extended_data_enable_ff && !field_odd_i && (line_num_i == EDS_LINE))); // R1

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			src_ff <= 1'b0;
		else if (arm)
			src_ff <= !field_odd_i;
	end

	// luma only: composite never reaches the slicer
	cdf_line_slicer u_slicer ( // R19
		.mclk_i       (mclk_i),
		.nrst_i       (nrst_i),
		.luma_i       (luma_i),
		.line_start_i (line_start_i),
		.arm_i        (arm),
		.byte_o       (slice_byte),
		.byte_vld_o   (slice_vld),
		.byte_high_o  (slice_high)
	);

	// parity bit travels with the code, tags sit above it
	assign entry = {src_ff, slice_high, slice_byte}; // R4 R5 R8

	assign full     = (count_ff == FULL_LEVEL);
	assign avail    = (count_ff != 5'h00);
	assign push_req = slice_vld && !flush;
	// a read frees a slot only after this cycle, so a write into a full
	// fifo is lost even when a read coincides
	assign pop  = reg_rd_i && (reg_addr_i == CAP_DATA_ADDR) && avail; // R12 R15
	assign push = push_req && !full && !ovf_ff; // R7 R16
	assign drop = push_req && (full || ovf_ff); // R13

	always_comb
	begin
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count  = count_ff;
		if (flush)
		begin
			nxt_rd_ptr = '0;
			nxt_count  = '0;
		end
		else
		begin
			if (pop)
				nxt_rd_ptr = rd_ptr_ff + PTR_STEP; // R12
			if (push && !pop)
				nxt_count = count_ff + CNT_STEP; // R21
			else if (pop && !push)
				nxt_count = count_ff - CNT_STEP; // R21
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end
		else
		begin
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
			if (flush)
				wr_ptr_ff <= '0; // R17
			else if (push)
				wr_ptr_ff <= wr_ptr_ff + PTR_STEP; // R21
		end
	end

	// read address runs one step ahead so the head entry is always ready
	cdf_entry_mem u_mem ( // R6
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.we_i    (push),
		.waddr_i (wr_ptr_ff),
		.wdata_i (entry),
		.raddr_i (nxt_rd_ptr),
		.rdata_o (head)
	);

	// overflow: a dropped byte sets it and wins over the data read clear, but flush wins over both
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			ovf_ff <= 1'b0;
		else if (flush)
			ovf_ff <= 1'b0;
		else if (drop)
			ovf_ff <= 1'b1; // R13
		else if (pop && !slice_vld)
			ovf_ff <= 1'b0; // R14 R16
	end

	// pin and mirror follow the fill level, so they fall on their own
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			int_ff <= 1'b0;
		else
			int_ff <= int_enable_ff && (count_ff >= HALF_LEVEL); // R10 R20
	end

	assign caption_interrupt_o = int_ff;

	always_comb
	begin
		status_byte            = RESET_BYTE;
		status_byte[ST_CAP_EN] = caption_enable_ff;
		status_byte[ST_EDS_EN] = extended_data_enable_ff;
		status_byte[ST_INT_EN] = int_enable_ff;
		status_byte[ST_AVAIL]  = avail; // R9
		status_byte[ST_OVF]    = ovf_ff;
		status_byte[ST_PERR]   = avail && !odd_ok(head[7:0]); // R5
		status_byte[ST_POS]    = avail && head[E_POS]; // R8
		status_byte[ST_SRC]    = avail && head[E_SRC]; // R8
	end

	// read data stand for exactly one cycle, zero otherwise
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			reg_rdata_o <= RESET_BYTE;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				GEN_STATUS_ADDR:
				begin
					reg_rdata_o              <= RESET_BYTE;
					reg_rdata_o[GEN_INT_BIT] <= int_ff; // R11
				end
				CAP_STATUS_ADDR:
					reg_rdata_o <= status_byte;
				CAP_DATA_ADDR:
					reg_rdata_o <= avail ? head[7:0] : RESET_BYTE; // R12
				default:
					reg_rdata_o <= RESET_BYTE;
			endcase
		end
		else
			reg_rdata_o <= RESET_BYTE;
	end

	AST_OVF_SET: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R13
		(slice_vld && !flush && full) |=> ovf_ff)
		else $error("byte into full fifo did not set overflow");

	AST_OVF_KEEP: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R16
		(ovf_ff && pop && slice_vld && !flush) |=> ovf_ff ##0 $stable(count_ff) == 1'b0)
		else $error("coinciding write cleared overflow");

	AST_OVF_CLR: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R14
		(ovf_ff && pop && !slice_vld) |=> !ovf_ff)
		else $error("clean data read did not clear overflow");

	AST_INT_RISE: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R10
		(int_enable_ff && count_ff >= HALF_LEVEL) |=> caption_interrupt_o)
		else $error("interrupt missing at half full");

	AST_INT_FALL: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R20
		(!int_enable_ff || count_ff < HALF_LEVEL) |=> !caption_interrupt_o)
		else $error("interrupt stayed high");

	AST_FLUSH: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R17
		flush |=> (count_ff == 5'h00) && !ovf_ff ##1 !status_byte[ST_AVAIL] || !flush)
		else $error("fifo not flushed with both enables off");

	AST_POP_COUNT: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R15
		(pop && !push && !flush) |=> count_ff == $past(count_ff) - CNT_STEP)
		else $error("data read did not release one entry");

	AST_FULL_HOLD: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R21
		(full && !pop && !flush) |=> full)
		else $error("full fifo changed without a read");

	AST_DATA_READ: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R12
		(pop) |=> reg_rdata_o == $past(head[7:0]))
		else $error("data read returned wrong byte");

	// the mirror is sampled at the read edge, so it matches the pin as it was then
	AST_MIRROR: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R11
		(reg_rd_i && reg_addr_i == GEN_STATUS_ADDR) |=>
			reg_rdata_o[GEN_INT_BIT] == $past(caption_interrupt_o))
		else $error("status mirror differs from pin");

	AST_AVAIL_READ: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R9
		(reg_rd_i && reg_addr_i == CAP_STATUS_ADDR) |=>
			reg_rdata_o[ST_AVAIL] == ($past(count_ff) != 5'h00))
		else $error("data available bit wrong");

	AST_PERR_READ: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R5
		(reg_rd_i && reg_addr_i == CAP_STATUS_ADDR) |=>
			reg_rdata_o[ST_PERR] == ($past(avail) && !(^$past(head[7:0]))))
		else $error("parity error bit wrong");

	AST_PUSH_COUNT: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R21
		(push && !pop && !flush) |=> count_ff == $past(count_ff) + CNT_STEP)
		else $error("stored byte did not take one entry");

	AST_DROP_COUNT: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R16
		(drop && !pop && !flush) |=> $stable(count_ff))
		else $error("dropped byte changed the fill level");

	AST_COUNT_MAX: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R6
		count_ff <= FULL_LEVEL)
		else $error("fill level beyond sixteen");

	// pointer distance and fill level must agree, full wraps to zero
	AST_PTR_GAP: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R21
		(wr_ptr_ff - rd_ptr_ff) == count_ff[PTR_W-1:0])
		else $error("pointers and fill level disagree");

	AST_POP_PTR: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R12
		(pop && !flush) |=> rd_ptr_ff == $past(rd_ptr_ff) + PTR_STEP)
		else $error("data read did not advance the head");

	AST_EMPTY_READ: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R12
		(reg_rd_i && reg_addr_i == CAP_DATA_ADDR && !avail && !flush) |=>
			(reg_rdata_o == RESET_BYTE) && $stable(rd_ptr_ff))
		else $error("empty data read moved the head");

	AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R12
		!reg_rd_i |=> reg_rdata_o == RESET_BYTE)
		else $error("read data outside the answer cycle");

	AST_FLUSH_PTR: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R17
		flush |=> (wr_ptr_ff == '0) && (rd_ptr_ff == '0))
		else $error("flush left pointers set");

	AST_FLUSH_OVF: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R17
		flush |=> !ovf_ff)
		else $error("flush left overflow set");
endmodule // cdf_capture_top

// >>> verification/cdf_luma_src.sv
// behavioural caption waveform source on the separated luma path
`timescale 1ns/1ps
module cdf_luma_src
	import cdf_pkg::*;
(
	input  wire logic        mclk_i, // system clock
	input  wire logic        go_i,   // pulse: send one line
	input  wire logic [2:0]  code_i, // start bits, msb sent first
	input  wire logic [15:0] word_i, // {high, low} byte, lsb first on air
	output logic      [7:0]  luma_o, // luma towards the capture block
	output logic             busy_o  // line in progress
);
	localparam logic [7:0] BLACK = 8'h10;
	localparam logic [7:0] WHITE = 8'hC0;
	logic [18:0] bits;
	initial
	begin
		luma_o = BLACK;
		busy_o = 1'b0;
		forever
		begin
			@(posedge mclk_i);
			if (go_i === 1'b1)
			begin
				busy_o <= 1'b1;
				bits = {word_i, code_i[0], code_i[1], code_i[2]};
				// short run-in: only its edges are counted, keeps the run brief
				repeat (6)
				begin
					luma_o <= WHITE;
					repeat (10) @(posedge mclk_i);
					luma_o <= BLACK;
					repeat (10) @(posedge mclk_i);
				end
				repeat (BIT_CYC - 20) @(posedge mclk_i);
				for (int k = 0; k < 19; k++)
				begin
					luma_o <= bits[k] ? WHITE : BLACK;
					repeat (BIT_CYC) @(posedge mclk_i);
				end
				luma_o <= BLACK;
				busy_o <= 1'b0;
			end
		end
	end
endmodule // cdf_luma_src

// >>> verification/cdf_capture_top_tb.sv
// self-checking bench for the caption capture fifo
`timescale 1ns/1ps
module cdf_capture_top_tb;
	import cdf_pkg::*;
	logic        mclk_i;
	logic        nrst_i;
	logic [8:0]  line_num_i;
	logic        field_odd_i;
	logic        line_start_i;
	logic [7:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic        caption_interrupt_o;
	logic [7:0]  luma;
	logic        go;
	logic [2:0]  code;
	logic [15:0] word;
	logic        busy;
	logic [31:0] seed;
	logic [9:0]  q[$];
	logic [7:0]  d;
	int          err_count;
	int          checked;

	cdf_capture_top cdf_capture_top_i (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .luma_i(luma), .line_start_i(line_start_i),
		.line_num_i(line_num_i), .field_odd_i(field_odd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .caption_interrupt_o(caption_interrupt_o));
	cdf_luma_src cdf_luma_src_i (
		.mclk_i(mclk_i), .go_i(go), .code_i(code), .word_i(word), .luma_o(luma),
		.busy_o(busy));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	function automatic logic [7:0] stat_exp(input logic [9:0] e, input logic ovf);
		return {e[E_SRC], e[E_POS], ~^e[7:0], ovf, 4'hF};
	endfunction

	task automatic close_out();
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// every bus task ends just after the edge that took its strobe
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		v = reg_rdata_o;
	endtask

	task automatic send_line(input logic [8:0] ln, input logic odd, input logic [2:0] sc,
			input logic [15:0] w);
		int n;
		n = 0;
		line_num_i <= ln;
		field_odd_i <= odd;
		line_start_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		line_start_i <= 1'b0;
		go <= 1'b1;
		code <= sc;
		word <= w;
		@(posedge mclk_i);
		#1;
		go <= 1'b0;
		while (busy === 1'b1 && n < 9000)
		begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		if (n >= 9000)
		begin
			err_count++;
			close_out();
		end
		repeat (4) @(posedge mclk_i);
		#1;
	endtask

	// status tags of the head first, then the data read that pops it
	task automatic pop_chk(input logic ovf);
		logic [9:0] e;
		e = q.pop_front();
		bus_rd(CAP_STATUS_ADDR, d);
		chk(d, stat_exp(e, ovf));
		chk({7'h00, caption_interrupt_o}, {7'h00, q.size() >= 7});
		bus_rd(CAP_DATA_ADDR, d);
		chk(d, e[7:0]);
	endtask

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	initial
	begin
		nrst_i = 1'b0;
		line_num_i = 9'h000;
		field_odd_i = 1'b0;
		line_start_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		go = 1'b0;
		code = 3'h0;
		word = 16'h0000;
		seed = 32'd63410;
		err_count = 0;
		checked = 0;
		repeat (8) @(posedge mclk_i);
		nrst_i <= 1'b1;
		#1;
		bus_rd(CAP_STATUS_ADDR, d);
		chk(d, RESET_BYTE);
		bus_rd(8'h55, d);
		chk(d, 8'h00);
		bus_wr(CAP_STATUS_ADDR, 8'h07);
		bus_wr(CAP_DATA_ADDR, 8'hAA);
		bus_rd(CAP_STATUS_ADDR, d);
		chk(d, 8'h07);
		seed = xs(seed);
		send_line(CAP_LINE, 1'b1, START_CODE, seed[15:0]);
		q.push_back({2'b00, seed[7:0]});
		q.push_back({2'b01, seed[15:8]});
		pop_chk(1'b0);
		pop_chk(1'b0);
		bus_wr(CAP_STATUS_ADDR, 8'h05);
		send_line(EDS_LINE, 1'b0, START_CODE, 16'h1234);
		send_line(CAP_LINE, 1'b1, 3'b011, 16'h5678);
		bus_wr(CAP_STATUS_ADDR, 8'h07);
		bus_rd(CAP_STATUS_ADDR, d);
		chk(d, 8'h07);
		bus_rd(CAP_DATA_ADDR, d);
		chk(d, 8'h00);
		// eight lines fill the store, the ninth finds it full
		for (int i = 0; i < 9; i++)
		begin
			seed = xs(seed);
			send_line(i[0] ? EDS_LINE : CAP_LINE, !i[0], START_CODE, seed[15:0]);
			if (i < 8)
			begin
				q.push_back({i[0], 1'b0, seed[7:0]});
				q.push_back({i[0], 1'b1, seed[15:8]});
			end
			chk({7'h00, caption_interrupt_o}, {7'h00, q.size() >= 8});
			bus_rd(GEN_STATUS_ADDR, d);
			chk(d, {7'h00, q.size() >= 8});
		end
		bus_wr(CAP_STATUS_ADDR, 8'h03);
		bus_rd(CAP_STATUS_ADDR, d);
		chk(d, stat_exp(q[0], 1'b1) & 8'hFB);
		chk({7'h00, caption_interrupt_o}, 8'h00);
		bus_wr(CAP_STATUS_ADDR, 8'h07);
		pop_chk(1'b1);
		for (int i = 0; i < 13; i++)
			pop_chk(1'b0);
		bus_wr(CAP_STATUS_ADDR, 8'h04);
		@(posedge mclk_i);
		#1;
		bus_rd(CAP_STATUS_ADDR, d);
		chk(d, 8'h04);
		bus_wr(CAP_STATUS_ADDR, 8'h07);
		bus_rd(CAP_DATA_ADDR, d);
		chk(d, 8'h00);
		close_out();
	end
endmodule // cdf_capture_top_tb
